// [hw/stcg_pkg.sv]
// Package of constants and carrier types for the serial terminal command gate.
// Summary of operation
// - The link runs at 9600 baud, 8 data bits, no parity, 1 stop bit.
// - Each end sends only while its peer's handshake line shows ready.
// - Before an Enter arrives, other command characters are ignored.
// - Enter opens a 60 second window for commands; then they are ignored.
// - Every received Enter makes the device send a full status report.
// - A lowercase o inside an open window sets the RF mute request.
// - A lowercase f inside an open window clears the RF mute request.
// - Frequency changes send a report; mute and unmute send nothing.
// - A report shows the measured values sampled when the report starts.
package stcg_pkg;

   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned BAUD_BPS      = 9600;
   localparam int unsigned BAUD_DIV      = CLK_HZ / BAUD_BPS;
   localparam int unsigned WINDOW_S      = 60;
   localparam longint unsigned WINDOW_CYCLES_L = longint'(WINDOW_S) * CLK_HZ;
   localparam int unsigned WINDOW_CYCLES = 32'(WINDOW_CYCLES_L);
   localparam int unsigned DATA_BITS     = 8;
   localparam int unsigned BAUD_W        = 13;
   localparam int unsigned WINDOW_W      = 32;

   localparam logic [7:0] CH_ENTER     = 8'h0D;
   localparam logic [7:0] CH_LINEFEED  = 8'h0A;
   localparam logic [7:0] CH_MUTE      = 8'h6F;
   localparam logic [7:0] CH_UNMUTE    = 8'h66;
   localparam logic [7:0] CH_FREQ_UP   = 8'h2B;
   localparam logic [7:0] CH_FREQ_DOWN = 8'h2D;
   localparam logic [7:0] CH_SPACE     = 8'h20;
   localparam logic [7:0] CH_TAG_FREQ  = 8'h46;
   localparam logic [7:0] CH_TAG_FWD   = 8'h50;
   localparam logic [7:0] CH_TAG_REV   = 8'h52;
   localparam logic [7:0] CH_TAG_MUTE  = 8'h4D;
   localparam logic [7:0] CH_ZERO      = 8'h30;
   localparam logic [7:0] CH_HEX_A     = 8'h41;
   localparam logic [4:0] REPORT_LAST  = 5'h11;

   typedef struct packed {
      logic [15:0] freq;
      logic [7:0]  fwd_power;
      logic [7:0]  rev_power;
   } stcg_status_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } stcg_rx_type;

   typedef enum logic [1:0] {
      STCG_IDLE  = 2'h0,
      STCG_START = 2'h1,
      STCG_DATA  = 2'h3,
      STCG_STOP  = 2'h2
   } stcg_line_type;

endpackage

// [hw/stcg_uart_rx.sv]
// Serial receiver: start bit search, mid-bit sampling, 8N1 framing.
`timescale 1ns/1ps
`default_nettype none
module stcg_uart_rx
   import stcg_pkg::*;
#(
   parameter int unsigned DIV = BAUD_DIV
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // Serial line
   input  wire logic         rxd,
   // Received character
   output stcg_rx_type       rx
);

   logic              rx_meta;
   logic              rx_sync;
   stcg_line_type     state;
   stcg_line_type     next_state;
   logic [BAUD_W-1:0] cnt;
   logic [BAUD_W-1:0] next_cnt;
   logic [2:0]        bit_cnt;
   logic [2:0]        next_bit_cnt;
   logic [7:0]        shift;
   logic [7:0]        next_shift;
   stcg_rx_type       next_rx;

   localparam logic [BAUD_W-1:0] FULL = BAUD_W'(DIV - 1);
   localparam logic [BAUD_W-1:0] HALF = BAUD_W'(DIV / 2 - 1);

   always_comb
   begin
      next_state   = state;
      next_cnt     = cnt + 1'b1;
      next_bit_cnt = bit_cnt;
      next_shift   = shift;
      next_rx      = '{valid: 1'b0, data: rx.data};
      case (state)
         STCG_IDLE:
         begin
            next_cnt = '0;
            if (!rx_sync)
               next_state = STCG_START;
         end
         STCG_START:
         begin
            // A glitch shorter than half a bit is rejected here.
            if (cnt == HALF)
            begin
               next_cnt     = '0;
               next_bit_cnt = '0;
               next_state   = rx_sync ? STCG_IDLE : STCG_DATA;
            end
         end
         STCG_DATA:
         begin
            if (cnt == FULL)
            begin
               next_cnt     = '0;
               next_shift   = {rx_sync, shift[7:1]};
               next_bit_cnt = bit_cnt + 1'b1;
               if (bit_cnt == 3'h7)
                  next_state = STCG_STOP;
            end
         end
         STCG_STOP:
         begin
            if (cnt == FULL)
            begin
               // A low stop bit is a framing error; the character is dropped.
               next_rx    = '{valid: rx_sync, data: shift};
               next_state = STCG_IDLE;
            end
         end
         default:
            next_state = STCG_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         state   <= STCG_IDLE;
         cnt     <= '0;
         bit_cnt <= '0;
         shift   <= '0;
         rx      <= '0;
      end
      else
      begin
         rx_meta <= rxd;
         rx_sync <= rx_meta;
         state   <= next_state;
         cnt     <= next_cnt;
         bit_cnt <= next_bit_cnt;
         shift   <= next_shift;
         rx      <= next_rx;
      end
   end

endmodule
`default_nettype wire

// [hw/stcg_gate.sv]
// Terminal command gate: Enter-armed window, mute control, status report.
`timescale 1ns/1ps
`default_nettype none
module stcg_gate
   import stcg_pkg::*;
#(
   parameter int unsigned DIV        = BAUD_DIV,
   parameter int unsigned WINDOW_CYC = WINDOW_CYCLES
)
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst_b,
   // Serial link to the terminal
   input  wire logic            rxd,
   output logic                 txd,
   input  wire logic            cts_b,
   output logic                 rts_b,
   // Measured transmitter values
   input  wire stcg_status_type status,
   // Transmitter controls
   output logic                 rf_mute,
   output logic                 freq_up,
   output logic                 freq_down,
   output logic                 window_open
);

   stcg_rx_type         rx;
   logic                cts_meta;
   logic                cts_sync;
   logic                pend_valid;
   logic                next_pend_valid;
   logic [7:0]          pend_data;
   logic [7:0]          next_pend_data;
   logic [WINDOW_W-1:0] win_cnt;
   logic [WINDOW_W-1:0] next_win_cnt;
   logic                next_window_open;
   logic                next_rf_mute;
   logic                next_freq_up;
   logic                next_freq_down;
   logic                next_rts_b;
   logic                report;
   logic                next_report;
   logic [4:0]          char_idx;
   logic [4:0]          next_char_idx;
   stcg_status_type     snap;
   stcg_status_type     next_snap;
   logic                snap_mute;
   logic                next_snap_mute;
   logic                auto_report;
   logic                next_auto_report;
   stcg_line_type       tx_state;
   stcg_line_type       next_tx_state;
   logic [BAUD_W-1:0]   baud_cnt;
   logic [BAUD_W-1:0]   next_baud_cnt;
   logic                baud_tick;
   logic [2:0]          bit_cnt;
   logic [2:0]          next_bit_cnt;
   logic [7:0]          tx_shift;
   logic [7:0]          next_tx_shift;
   logic                next_txd;

   localparam logic [BAUD_W-1:0]   BAUD_LAST = BAUD_W'(DIV - 1);
   localparam logic [WINDOW_W-1:0] WIN_LAST  = WINDOW_W'(WINDOW_CYC - 1);

   stcg_uart_rx #(.DIV(DIV)) u_rx
   (
      .clk   (clk),
      .rst_b (rst_b),
      .rxd   (rxd),
      .rx    (rx)
   );

   function automatic logic [7:0] hex_char(input logic [3:0] nib);
      hex_char = (nib < 4'hA) ? CH_ZERO + {4'h0, nib}
                              : CH_HEX_A + {4'h0, nib} - 8'h0A;
   endfunction

   // Report line: F hhhh P hh R hh M m CR LF.
   function automatic logic [7:0] report_char(input logic [4:0] idx,
                                              input stcg_status_type s,
                                              input logic m);
      case (idx)
         5'h00:   report_char = CH_TAG_FREQ;
         5'h01:   report_char = hex_char(s.freq[15:12]);
         5'h02:   report_char = hex_char(s.freq[11:8]);
         5'h03:   report_char = hex_char(s.freq[7:4]);
         5'h04:   report_char = hex_char(s.freq[3:0]);
         5'h05:   report_char = CH_SPACE;
         5'h06:   report_char = CH_TAG_FWD;
         5'h07:   report_char = hex_char(s.fwd_power[7:4]);
         5'h08:   report_char = hex_char(s.fwd_power[3:0]);
         5'h09:   report_char = CH_SPACE;
         5'h0A:   report_char = CH_TAG_REV;
         5'h0B:   report_char = hex_char(s.rev_power[7:4]);
         5'h0C:   report_char = hex_char(s.rev_power[3:0]);
         5'h0D:   report_char = CH_SPACE;
         5'h0E:   report_char = CH_TAG_MUTE;
         5'h0F:   report_char = hex_char({3'h0, m});
         5'h10:   report_char = CH_ENTER;
         default: report_char = CH_LINEFEED;
      endcase
   endfunction

   assign baud_tick = (baud_cnt == BAUD_LAST);

   always_comb
   begin
      next_pend_valid  = pend_valid;
      next_pend_data   = pend_data;
      next_win_cnt     = win_cnt;
      next_window_open = window_open;
      next_rf_mute     = rf_mute;
      next_freq_up     = 1'b0;
      next_freq_down   = 1'b0;
      next_report      = report;
      next_char_idx    = char_idx;
      next_snap        = snap;
      next_snap_mute   = snap_mute;
      next_auto_report = 1'b0;
      next_tx_state    = tx_state;
      next_baud_cnt    = '0;
      next_bit_cnt     = bit_cnt;
      next_tx_shift    = tx_shift;
      next_txd         = txd;

      if (window_open)
      begin
         next_win_cnt = win_cnt - 1'b1;
         if (win_cnt == '0)
            next_window_open = 1'b0;
      end

      // Frequency commands report one cycle later so the new setting shows.
      if (auto_report)
      begin
         next_report    = 1'b1;
         next_char_idx  = '0;
         next_snap      = status;
         next_snap_mute = rf_mute;
      end

      // One character is held; the peer is told to wait while it is.
      if (pend_valid && !report && !auto_report)
      begin
         next_pend_valid = 1'b0;
         case (pend_data)
            CH_ENTER:
            begin
               next_window_open = 1'b1;
               next_win_cnt     = WIN_LAST;
               next_report      = 1'b1;
               next_char_idx    = '0;
               next_snap        = status;
               next_snap_mute   = rf_mute;
            end
            CH_MUTE:
               if (window_open)
                  next_rf_mute = 1'b1;
            CH_UNMUTE:
               if (window_open)
                  next_rf_mute = 1'b0;
            CH_FREQ_UP:
               if (window_open)
               begin
                  next_freq_up     = 1'b1;
                  next_auto_report = 1'b1;
               end
            CH_FREQ_DOWN:
               if (window_open)
               begin
                  next_freq_down   = 1'b1;
                  next_auto_report = 1'b1;
               end
            default:
               next_pend_valid = 1'b0;
         endcase
      end
      if (rx.valid && !pend_valid)
      begin
         next_pend_valid = 1'b1;
         next_pend_data  = rx.data;
      end

      case (tx_state)
         STCG_IDLE:
         begin
            next_txd = 1'b1;
            // A character starts only while the peer shows ready.
            if (report && !cts_sync)
            begin
               next_tx_shift = report_char(char_idx, snap, snap_mute);
               next_txd      = 1'b0;
               next_tx_state = STCG_START;
               next_char_idx = char_idx + 1'b1;
               if (char_idx == REPORT_LAST)
                  next_report = 1'b0;
            end
         end
         STCG_START:
         begin
            next_baud_cnt = baud_cnt + 1'b1;
            if (baud_tick)
            begin
               next_baud_cnt = '0;
               next_bit_cnt  = '0;
               next_txd      = tx_shift[0];
               next_tx_state = STCG_DATA;
            end
         end
         STCG_DATA:
         begin
            next_baud_cnt = baud_cnt + 1'b1;
            if (baud_tick)
            begin
               next_baud_cnt = '0;
               next_bit_cnt  = bit_cnt + 1'b1;
               next_tx_shift = {1'b0, tx_shift[7:1]};
               next_txd      = tx_shift[1];
               if (bit_cnt == 3'h7)
               begin
                  next_txd      = 1'b1;
                  next_tx_state = STCG_STOP;
               end
            end
         end
         STCG_STOP:
         begin
            next_baud_cnt = baud_cnt + 1'b1;
            if (baud_tick)
               next_tx_state = STCG_IDLE;
         end
         default:
            next_tx_state = STCG_IDLE;
      endcase

      next_rts_b = next_pend_valid;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cts_meta    <= 1'b1;
         cts_sync    <= 1'b1;
         pend_valid  <= 1'b0;
         pend_data   <= '0;
         win_cnt     <= '0;
         window_open <= 1'b0;
         rf_mute     <= 1'b0;
         freq_up     <= 1'b0;
         freq_down   <= 1'b0;
         rts_b       <= 1'b0;
         report      <= 1'b0;
         char_idx    <= '0;
         snap        <= '0;
         snap_mute   <= 1'b0;
         auto_report <= 1'b0;
         tx_state    <= STCG_IDLE;
         baud_cnt    <= '0;
         bit_cnt     <= '0;
         tx_shift    <= '0;
         txd         <= 1'b1;
      end
      else
      begin
         cts_meta    <= cts_b;
         cts_sync    <= cts_meta;
         pend_valid  <= next_pend_valid;
         pend_data   <= next_pend_data;
         win_cnt     <= next_win_cnt;
         window_open <= next_window_open;
         rf_mute     <= next_rf_mute;
         freq_up     <= next_freq_up;
         freq_down   <= next_freq_down;
         rts_b       <= next_rts_b;
         report      <= next_report;
         char_idx    <= next_char_idx;
         snap        <= next_snap;
         snap_mute   <= next_snap_mute;
         auto_report <= next_auto_report;
         tx_state    <= next_tx_state;
         baud_cnt    <= next_baud_cnt;
         bit_cnt     <= next_bit_cnt;
         tx_shift    <= next_tx_shift;
         txd         <= next_txd;
      end
   end

endmodule
`default_nettype wire

// [bench/stcg_gate_props.sv]
// Port-level assertions for the terminal command gate.
`timescale 1ns/1ps
`default_nettype none
module stcg_gate_props
#(
   parameter int unsigned DIV        = 8,
   parameter int unsigned WINDOW_CYC = 2000
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Serial link
   input  wire logic txd,
   input  wire logic cts_b,
   // Controls
   input  wire logic rf_mute,
   input  wire logic freq_up,
   input  wire logic freq_down,
   input  wire logic window_open
);
   // A frame counter finds start bits, so falling data bits are not taken
   // for a new character.
   logic        prev_txd;
   logic        start;
   logic [31:0] cnt;
   logic [31:0] wlen;
   logic [31:0] next_cnt;
   logic [31:0] next_wlen;

   assign start = prev_txd && !txd && cnt == '0;

   always_comb
   begin
      next_cnt = start ? 10 * DIV - 1 : (cnt != '0 ? cnt - 1 : '0);
      next_wlen = window_open ? wlen + 1 : '0;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prev_txd <= 1'b1;
         cnt      <= '0;
         wlen     <= '0;
      end
      else
      begin
         prev_txd <= txd;
         cnt      <= next_cnt;
         wlen     <= next_wlen;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_up_pulse:
      assert property (freq_up |=> !freq_up)
      else $error("freq_up wider than one cycle");
   a_down_pulse:
      assert property (freq_down |=> !freq_down)
      else $error("freq_down wider than one cycle");
   a_up_gated:
      assert property (freq_up |-> $past(window_open))
      else $error("freq_up outside the window");
   a_down_gated:
      assert property (freq_down |-> $past(window_open))
      else $error("freq_down outside the window");
   a_mute_gated:
      assert property ($changed(rf_mute) |-> $past(window_open))
      else $error("mute changed outside the window");
   a_start_low:
      assert property (cnt == 10 * DIV - DIV / 2 |-> !txd)
      else $error("start bit not low");
   a_stop_high:
      assert property (cnt == DIV / 2 |-> txd)
      else $error("stop bit not high");
   a_tx_paced:
      assert property (start |-> !$past(cts_b, 3) || !$past(cts_b, 4))
      else $error("character started while peer not ready");
   a_win_length:
      assert property ($fell(window_open) |-> wlen >= WINDOW_CYC)
      else $error("window closed early");

   c_up: cover property (freq_up);
   c_mute: cover property ($rose(rf_mute));
   c_close: cover property ($fell(window_open));
endmodule

bind stcg_gate stcg_gate_props #(
   .DIV        (DIV),
   .WINDOW_CYC (WINDOW_CYC)
) u_props (
   .clk         (clk),
   .rst_b       (rst_b),
   .txd         (txd),
   .cts_b       (cts_b),
   .rf_mute     (rf_mute),
   .freq_up     (freq_up),
   .freq_down   (freq_down),
   .window_open (window_open)
);
`default_nettype wire

// [bench/stcg_term.sv]
// Remote terminal model: paced serial sender and report receiver.
`timescale 1ns/1ps
`default_nettype none
module stcg_term
#(
   parameter int DIV = 8
)
(
   // Clock
   input  wire logic clk,
   // Serial link
   output logic      rxd,
   input  wire logic txd,
   input  wire logic rts_b
);
   logic [7:0] got[$];
   int         n_bad = 0;
   logic [7:0] b;

   initial
      rxd = 1'b1;

   task automatic send(input logic [7:0] c);
      while (rts_b) @(posedge clk);
      rxd <= 1'b0;
      repeat (DIV) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         rxd <= c[i];
         repeat (DIV) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (2 * DIV) @(posedge clk);
   endtask

   // Samples each bit in its middle, away from the edges where it moves.
   always
   begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge clk);
      if (txd !== 1'b0) n_bad++;
      for (int i = 0; i < 8; i++)
      begin
         repeat (DIV) @(posedge clk);
         b[i] = txd;
      end
      repeat (DIV) @(posedge clk);
      if (txd !== 1'b1) n_bad++;
      got.push_back(b);
   end
endmodule
`default_nettype wire

// [bench/stcg_gate_tb.sv]
// Self-checking bench for the serial terminal command gate.
`timescale 1ns/1ps
`default_nettype none
module stcg_gate_tb
   import stcg_pkg::*;
;
   localparam int DIV   = 8;
   localparam int WCYC  = 6000;
   localparam int LIMIT = 60000;

   logic            clk = 1'b0;
   logic            rst_b = 1'b0;
   logic            rxd;
   logic            txd;
   logic            cts_b = 1'b0;
   logic            rts_b;
   stcg_status_type status = '0;
   logic            rf_mute;
   logic            freq_up;
   logic            freq_down;
   logic            window_open;
   int              n_mismatch = 0;
   int              cmp_count = 0;
   int              cyc = 0;
   int              n_up = 0;
   int              n_dn = 0;
   int              up_m = 0;
   int              dn_m = 0;
   int              wlen = 0;
   int              wlast = 0;
   logic            mute_m = 1'b0;
   logic            win_m = 1'b0;
   logic [7:0]      exp_q[$];

   always #10 clk = ~clk;

   stcg_gate #(
      .DIV        (DIV),
      .WINDOW_CYC (WCYC)
   ) uut (
      .clk         (clk),
      .rst_b       (rst_b),
      .rxd         (rxd),
      .txd         (txd),
      .cts_b       (cts_b),
      .rts_b       (rts_b),
      .status      (status),
      .rf_mute     (rf_mute),
      .freq_up     (freq_up),
      .freq_down   (freq_down),
      .window_open (window_open)
   );

   stcg_term #(
      .DIV (DIV)
   ) u_term (
      .clk   (clk),
      .rxd   (rxd),
      .txd   (txd),
      .rts_b (rts_b)
   );

   task automatic results();
      $display("Compared %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (freq_up === 1'b1) n_up++;
      if (freq_down === 1'b1) n_dn++;
      if (window_open === 1'b1) wlen++;
      else if (wlen != 0)
      begin
         wlast = wlen;
         wlen = 0;
      end
      if (cyc == LIMIT)
      begin
         n_mismatch++;
         results();
      end
   end

   task automatic chk_flag(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t flag %b, expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t value %0h, expected %0h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? CH_ZERO + 8'(n) : CH_HEX_A + 8'(n) - 8'h0A;
   endfunction

   task automatic rep();
      exp_q = {exp_q, CH_TAG_FREQ, hx(status.freq[15:12]),
         hx(status.freq[11:8]), hx(status.freq[7:4]), hx(status.freq[3:0]),
         CH_SPACE, CH_TAG_FWD, hx(status.fwd_power[7:4]),
         hx(status.fwd_power[3:0]), CH_SPACE, CH_TAG_REV,
         hx(status.rev_power[7:4]), hx(status.rev_power[3:0]), CH_SPACE,
         CH_TAG_MUTE, CH_ZERO + 8'(mute_m), CH_ENTER, CH_LINEFEED};
   endtask

   // Waits for the expected bytes, then a while longer to catch extras.
   task automatic drain();
      int n = 0;
      while (u_term.got.size() < exp_q.size() && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      repeat (24 * DIV) @(posedge clk);
      chk_val(32'(u_term.got.size()), 32'(exp_q.size()));
      foreach (exp_q[i])
         chk_val(32'(u_term.got[i]), 32'(exp_q[i]));
      chk_val(32'(u_term.n_bad), 32'h0);
      exp_q = {};
      u_term.got = {};
   endtask

   task automatic cmd(input logic [7:0] c);
      if (c == CH_ENTER)
      begin
         win_m = 1'b1;
         rep();
      end
      else if (win_m && (c == CH_MUTE || c == CH_UNMUTE))
         mute_m = (c == CH_MUTE);
      else if (win_m && (c == CH_FREQ_UP || c == CH_FREQ_DOWN))
      begin
         if (c == CH_FREQ_UP) up_m++;
         else dn_m++;
         rep();
      end
      u_term.send(c);
      chk_flag(rf_mute, mute_m);
      chk_flag(window_open, win_m);
      chk_val(32'(n_up), 32'(up_m));
      chk_val(32'(n_dn), 32'(dn_m));
      drain();
   endtask

   function automatic logic [7:0] junk();
      logic [7:0] j;
      do j = 8'($urandom);
      while (j inside {CH_ENTER, CH_MUTE, CH_UNMUTE, CH_FREQ_UP,
                       CH_FREQ_DOWN});
      return j;
   endfunction

   task automatic new_status();
      @(posedge clk);
      status <= stcg_status_type'($urandom);
      @(posedge clk);
   endtask

   task automatic stall();
      repeat (300) @(posedge clk);
      cts_b <= 1'b1;
      repeat (100 + $urandom_range(500)) @(posedge clk);
      cts_b <= 1'b0;
   endtask

   task automatic wait_close();
      int n = 0;
      while (window_open !== 1'b0 && n < 2 * WCYC)
      begin
         @(posedge clk);
         n++;
      end
      win_m = 1'b0;
      @(posedge clk);
   endtask

   initial
   begin
      void'($urandom(32'hD7CA1E71));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      chk_flag(txd, 1'b1);
      chk_flag(rts_b, 1'b0);
      cmd(CH_MUTE);
      cmd(CH_FREQ_UP);
      cmd(CH_FREQ_DOWN);
      new_status();
      cmd(CH_ENTER);
      cmd(CH_MUTE);
      cmd(junk());
      new_status();
      fork
         cmd(CH_FREQ_UP);
         stall();
      join
      cmd(CH_ENTER);
      cmd(CH_UNMUTE);
      cmd(CH_FREQ_DOWN);
      wait_close();
      cmd(CH_MUTE);
      cmd(CH_ENTER);
      cmd(junk());
      wait_close();
      chk_val(32'(wlast), 32'(WCYC));
      results();
   end
endmodule
`default_nettype wire
